// ---- rtl/eer_exit_record.sv ----
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "eer_params.svh"
// Notes on behaviour
// RL1 - Exit-reason word goes to byte 160 of the register save region.
// RL2 - Bits 7:0 carry exception number; bits 30:11 are zero.
// RL3 - Exit type 011b for hardware, 110b for software exceptions.
// RL4 - Valid bit 31 set only for exceptions reported inside the enclave.
// RL5 - Unreported exceptions clear vector and type fields.
// RL6 - Vectors 0,1,3,5,6,16,17,19 always reported.
// RL7 - Vectors 13 and 14 reported only with extended-info select set.
// RL8 - Vector 21 reported only with control-protection select set.
// RL9 - Reported vectors equal handler vectors; others not reported.
// RL10 - Higher-priority event wins: word is zero, debug delivered afterward.
// RL11 - Misc component i saved only when select bit i is set.
// RL12 - Extended record takes 16 bytes just below register save region.
// RL13 - No capability bits means no misc region; else highest bit plus size.
// RL14 - Record written when matching capability and select bits are both set.
// RL15 - Address field holds fault address for page faults, else zero.
// RL16 - Error code at record offset 8 for protection and page faults.
// RL17 - Page-fault bits 0,1,3,4 keep their ordinary meaning.
// RL18 - Page-fault bit 2 is always reported as 1.
// RL19 - Bit 5 key fault, bit 15 page-map fault, bits 14:6 reserved.
// RL20 - Supervisor-mode page faults are not recorded in the extended record.
// RL21 - Reserved last word of the record is written as zero.
module eer_exit_record (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire eer_pkg::eer_apb_req_t apb_req,
   output eer_pkg::eer_apb_rsp_t apb_rsp,
   // Exception event from the core
   input wire logic exc_valid,
   input wire eer_pkg::eer_event_t exc_info,
   input wire logic pf_user_ref,
   input wire logic priority_event,
   // Outputs to the save-frame writer
   output logic frame_write,
   output logic [31:0] frame_reason_off,
   output logic [31:0] frame_reason,
   output logic rec_write,
   output logic [31:0] rec_base_off,
   output logic [63:0] rec_addr,
   output logic [31:0] rec_err_code,
   output logic [31:0] rec_rsvd,
   output logic debug_redeliver
);
   import eer_pkg::*;

   logic [31:0] caps_reg;
   logic [31:0] select_reg;
   logic [31:0] frame_size_reg;
   logic [31:0] status_reg;
   logic dbg_pend_reg;
   logic [31:0] prdata_next;
   logic slverr_next;
   logic reported;
   logic ext_vec;
   logic cp_vec;
   logic rec_ok;
   logic [31:0] reason_next;
   logic [31:0] err_next;
   logic [4:0] hi_bit;
   logic [31:0] misc_size;
   logic [31:0] gpr_off;
   logic access;
   eer_state_t state_reg;
   // Macro literal cannot be bit-selected directly
   localparam logic [31:0] ALWAYS_VEC = `EER_ALWAYS_MASK;

   assign access = apb_req.psel && apb_req.penable;
   assign gpr_off = frame_size_reg - `EER_GPR_REGION_SIZE;

   // Vector classification
   always_comb begin
      ext_vec = (exc_info.vector == `EER_VEC_GP) || (exc_info.vector == `EER_VEC_PF);
      cp_vec = exc_info.vector == `EER_VEC_CP;
      reported = 1'b0;
      if (exc_info.vector < 8'h20 && ALWAYS_VEC[exc_info.vector[4:0]]) begin
         reported = 1'b1; // [RL6] [RL9]
      end
      if (ext_vec && select_reg[`EER_SEL_EXT]) begin
         reported = 1'b1; // [RL7]
      end
      if (cp_vec && select_reg[`EER_SEL_CP]) begin
         reported = 1'b1; // [RL8]
      end
   end

   // Exit-reason word
   always_comb begin
      reason_next = 32'h00000000; // [RL2] [RL5]
      if (reported && !priority_event) begin
         reason_next[`EER_VEC_LSB +: 8] = exc_info.vector; // [RL2]
         reason_next[`EER_TYPE_LSB +: 3] = exc_info.sw_type ? `EER_TYPE_SW
                                                            : `EER_TYPE_HW; // [RL3]
         reason_next[`EER_VALID_BIT] = 1'b1; // [RL4]
      end
   end

   // Record gating and error code
   always_comb begin
      rec_ok = 1'b0;
      if (ext_vec) begin
         rec_ok = caps_reg[`EER_SEL_EXT] && select_reg[`EER_SEL_EXT]; // [RL14] [RL11]
      end else if (cp_vec) begin
         rec_ok = caps_reg[`EER_SEL_CP] && select_reg[`EER_SEL_CP]; // [RL14] [RL11]
      end
      if (exc_info.vector == `EER_VEC_PF && !pf_user_ref) begin
         rec_ok = 1'b0; // [RL20]
      end
      if (priority_event) begin
         rec_ok = 1'b0;
      end
      err_next = exc_info.err_code;
      if (exc_info.vector == `EER_VEC_PF) begin
         err_next = exc_info.err_code & `EER_PF_KEEP_MASK; // [RL17] [RL19]
         err_next[`EER_PF_USER_BIT] = 1'b1; // [RL18]
      end
      if (!ext_vec) begin
         err_next = 32'h00000000; // [RL16]
      end
   end

   // Misc region size from the highest select bit
   always_comb begin
      hi_bit = 5'd0;
      for (int i = 0; i < 32; i++) begin
         if (select_reg[i]) begin
            hi_bit = 5'(i);
         end
      end
      misc_size = 32'h00000000;
      if (caps_reg != 32'h00000000 && select_reg != 32'h00000000) begin
         misc_size = (32'(hi_bit) + 32'd1) * `EER_REC_SIZE; // [RL13]
      end
   end

   // Event capture; one write burst per exit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= EER_IDLE;
         frame_write <= 1'b0;
         frame_reason_off <= 32'h00000000;
         frame_reason <= 32'h00000000;
         rec_write <= 1'b0;
         rec_base_off <= 32'h00000000;
         rec_addr <= 64'h0000000000000000;
         rec_err_code <= 32'h00000000;
         rec_rsvd <= 32'h00000000;
      end else begin
         frame_write <= 1'b0;
         rec_write <= 1'b0;
         state_reg <= EER_IDLE;
         if (exc_valid) begin
            state_reg <= EER_HELD;
            frame_write <= 1'b1;
            frame_reason_off <= gpr_off + `EER_REASON_OFFSET; // [RL1]
            frame_reason <= reason_next; // [RL10]
            rec_write <= rec_ok;
            if (rec_ok) begin
               rec_base_off <= gpr_off - `EER_REC_SIZE; // [RL12]
               rec_addr <= (exc_info.vector == `EER_VEC_PF) ? exc_info.addr
                                                           : 64'h0000000000000000; // [RL15]
               rec_err_code <= err_next; // [RL16]
               rec_rsvd <= 32'h00000000; // [RL21]
            end
         end
      end
   end

   // Debug exception deferred behind a higher-priority event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbg_pend_reg <= 1'b0;
         debug_redeliver <= 1'b0;
      end else begin
         debug_redeliver <= 1'b0;
         if (exc_valid && priority_event && exc_info.vector == 8'h01) begin
            dbg_pend_reg <= 1'b1; // [RL10]
         end else if (dbg_pend_reg && !priority_event) begin
            dbg_pend_reg <= 1'b0;
            debug_redeliver <= 1'b1; // [RL10]
         end
      end
   end

   // Status: last outcome, sticky until overwritten by next exit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= 32'h00000000;
      end else if (exc_valid) begin
         status_reg <= {29'h0, priority_event, rec_ok, reported};
      end
   end

   // Register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         caps_reg <= `EER_CAPS_RST;
         select_reg <= `EER_SELECT_RST;
         frame_size_reg <= 32'h00001000;
      end else if (access && apb_req.pwrite) begin
         case (apb_req.paddr)
            `EER_OFF_CTRL: begin
               frame_size_reg <= apb_req.pwdata;
            end
            `EER_OFF_CAPS: begin
               caps_reg <= apb_req.pwdata;
            end
            `EER_OFF_SELECT: begin
               // Select is masked by the capability value held when select is written
               select_reg <= apb_req.pwdata & caps_reg;
            end
            default: begin
            end
         endcase
      end
   end

   // Read mux
   always_comb begin
      prdata_next = 32'h00000000;
      slverr_next = 1'b0;
      case (apb_req.paddr)
         `EER_OFF_CTRL: prdata_next = frame_size_reg;
         `EER_OFF_CAPS: prdata_next = caps_reg;
         `EER_OFF_SELECT: prdata_next = select_reg;
         `EER_OFF_STATUS: prdata_next = status_reg;
         `EER_OFF_REASON: prdata_next = frame_reason;
         `EER_OFF_ADDR_LO: prdata_next = rec_addr[31:0];
         `EER_OFF_ADDR_HI: prdata_next = rec_addr[63:32];
         `EER_OFF_ERRCODE: prdata_next = rec_err_code;
         `EER_OFF_REC_RSVD: prdata_next = rec_rsvd;
         `EER_OFF_MISC_OFF: prdata_next = (misc_size == 32'h00000000) ? 32'h00000000
                                                                       : gpr_off - misc_size;
         `EER_OFF_MISC_SIZE: prdata_next = misc_size;
         `EER_OFF_DBG_PEND: prdata_next = {31'h0, dbg_pend_reg};
         default: slverr_next = 1'b1;
      endcase
   end

   // No wait state: answer registered from the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready <= apb_req.psel && !apb_req.penable;
         apb_rsp.pslverr <= apb_req.psel && !apb_req.penable && slverr_next;
         apb_rsp.prdata <= (apb_req.psel && !apb_req.penable) ? prdata_next : 32'h00000000;
      end
   end
endmodule

// ---- rtl/eer_params.svh ----
`ifndef EER_PARAMS_SVH
`define EER_PARAMS_SVH

// Bus map
`define EER_OFF_CTRL 12'h000
`define EER_OFF_CAPS 12'h004
`define EER_OFF_SELECT 12'h008
`define EER_OFF_STATUS 12'h00C
`define EER_OFF_REASON 12'h010
`define EER_OFF_ADDR_LO 12'h014
`define EER_OFF_ADDR_HI 12'h018
`define EER_OFF_ERRCODE 12'h01C
`define EER_OFF_REC_RSVD 12'h020
`define EER_OFF_MISC_OFF 12'h024
`define EER_OFF_MISC_SIZE 12'h028
`define EER_OFF_DBG_PEND 12'h02C

// Layout of the save frame
`define EER_GPR_REGION_SIZE 32'd176
`define EER_REASON_OFFSET 32'd160
`define EER_REC_SIZE 32'd16
`define EER_REC_ADDR_OFF 32'd0
`define EER_REC_ERR_OFF 32'd8
`define EER_REC_RSVD_OFF 32'd12

// Exit-reason fields
`define EER_VEC_LSB 0
`define EER_TYPE_LSB 8
`define EER_VALID_BIT 31
`define EER_TYPE_HW 3'h3
`define EER_TYPE_SW 3'h6

// Vectors
`define EER_VEC_GP 8'h0D
`define EER_VEC_PF 8'h0E
`define EER_VEC_CP 8'h15
`define EER_ALWAYS_MASK 32'h000B006B

// Select bits
`define EER_SEL_EXT 0
`define EER_SEL_CP 1

// Page-fault error code bits
`define EER_PF_USER_BIT 2
`define EER_PF_KEEP_MASK 32'h0000803B

// Reset values
`define EER_CAPS_RST 32'h00000003
`define EER_SELECT_RST 32'h00000000

`endif

// ---- rtl/eer_pkg.sv ----
package eer_pkg;
   typedef struct packed {
      logic [7:0] vector;
      logic sw_type;
      logic has_addr;
      logic [63:0] addr;
      logic [31:0] err_code;
   } eer_event_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } eer_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } eer_apb_rsp_t;

   typedef enum logic [1:0] {
      EER_IDLE = 2'b00,
      EER_HELD = 2'b01,
      EER_DONE = 2'b10
   } eer_state_t;
endpackage

// ---- tb/eer_exit_record_properties.sv ----
`timescale 1ns/1ps
module eer_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Exception event
   input wire logic exc_valid,
   input wire eer_pkg::eer_event_t exc_info,
   input wire logic pf_user_ref,
   input wire logic priority_event,
   // Save-frame outputs
   input wire logic frame_write,
   input wire logic [31:0] frame_reason_off,
   input wire logic [31:0] frame_reason,
   input wire logic rec_write,
   input wire logic [31:0] rec_base_off,
   input wire logic [63:0] rec_addr,
   input wire logic [31:0] rec_err_code,
   input wire logic [31:0] rec_rsvd
);
   import eer_pkg::*;
   localparam logic [31:0] ALWAYS_SET = 32'h000B006B;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_taken;
      exc_valid ##1 frame_write;
   endsequence
   sequence s_plain;
      exc_valid && !priority_event && exc_info.vector < 8'h20 && ALWAYS_SET[exc_info.vector[4:0]];
   endsequence
   property p_pulse;
      exc_valid |-> s_taken;
   endproperty
   a_pulse: assert property (p_pulse) else $error("no frame write after exit");
   property p_resv;
      frame_write |-> frame_reason[30:11] == 20'h00000;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved reason bits set");
   property p_type;
      frame_write && frame_reason[31] |-> frame_reason[10:8] inside {3'h3, 3'h6};
   endproperty
   a_type: assert property (p_type) else $error("bad exit type");
   property p_clear;
      frame_write && !frame_reason[31] |-> frame_reason[10:0] == 11'h000;
   endproperty
   a_clear: assert property (p_clear) else $error("unreported fields not cleared");
   property p_always;
      s_plain |=> frame_reason == {1'b1, 20'h00000, ($past(exc_info.sw_type) ? 3'h6 : 3'h3),
         $past(exc_info.vector)};
   endproperty
   a_always: assert property (p_always) else $error("fixed vector not reported");
   property p_prio;
      exc_valid && priority_event && exc_info.vector == 8'h01 |=> frame_reason == 32'h0 && !rec_write;
   endproperty
   a_prio: assert property (p_prio) else $error("debug not overridden");
   property p_pfsup;
      exc_valid && exc_info.vector == 8'h0E && !pf_user_ref |=> !rec_write;
   endproperty
   a_pfsup: assert property (p_pfsup) else $error("supervisor fault recorded");
   property p_pfcode;
      rec_write && $past(exc_info.vector) == 8'h0E |-> rec_err_code[2] &&
         rec_err_code[14:6] == 9'h000 && rec_addr == $past(exc_info.addr);
   endproperty
   a_pfcode: assert property (p_pfcode) else $error("page fault record wrong");
   property p_noaddr;
      rec_write && $past(exc_info.vector) != 8'h0E |-> rec_addr == 64'h0;
   endproperty
   a_noaddr: assert property (p_noaddr) else $error("address not cleared");
   property p_layout;
      rec_write |-> frame_reason_off == rec_base_off + 32'd176 && rec_rsvd == 32'h0;
   endproperty
   a_layout: assert property (p_layout) else $error("record placement wrong");
   property p_rec;
      rec_write |-> frame_write && frame_reason[31];
   endproperty
   a_rec: assert property (p_rec) else $error("record for unreported exit");
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
   import eer_pkg::*;
   localparam logic [31:0] ALWAYS_SET = 32'h000B006B;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   eer_apb_req_t apb_req = '0;
   eer_apb_rsp_t apb_rsp;
   logic exc_valid = 1'b0;
   eer_event_t exc_info = '0;
   logic pf_user_ref = 1'b1;
   logic priority_event = 1'b0;
   logic frame_write, rec_write, debug_redeliver;
   logic [31:0] frame_reason_off, frame_reason, rec_base_off, rec_err_code, rec_rsvd;
   logic [63:0] rec_addr;
   logic [31:0] sel = 32'h0;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   eer_exit_record eer_exit_record_inst (.pclk, .presetn, .apb_req, .apb_rsp, .exc_valid,
      .exc_info, .pf_user_ref, .priority_event, .frame_write, .frame_reason_off, .frame_reason,
      .rec_write, .rec_base_off, .rec_addr, .rec_err_code, .rec_rsvd, .debug_redeliver);
   always #5 pclk = ~pclk;
   // Sweep plus register traffic needs well under this
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         end_sim();
      end
   end
   task end_sim();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      @(posedge pclk);
      apb_req <= '{a, 1'b1, 1'b0, w, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
      q = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   task rd(input string n, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(a, 1'b0, 32'h0, q, e);
      chk(n, q, exp);
   endtask
   // Samples on the falling edge after the registered answer lands
   task exc(input logic [7:0] v, input logic sw, input logic [63:0] ad, input logic [31:0] ec,
      input logic usr, input logic pr);
      @(posedge pclk);
      exc_valid <= 1'b1;
      exc_info <= '{v, sw, 1'b0, ad, ec};
      pf_user_ref <= usr;
      priority_event <= pr;
      @(posedge pclk);
      exc_valid <= 1'b0;
      @(negedge pclk);
   endtask
   function automatic logic [31:0] exp_word(input logic [7:0] v, input logic sw);
      logic rep;
      rep = (v < 8'h20 && ALWAYS_SET[v[4:0]]) || ((v == 8'h0D || v == 8'h0E) && sel[0]) ||
         (v == 8'h15 && sel[1]);
      return rep ? {1'b1, 20'h00000, (sw ? 3'h6 : 3'h3), v} : 32'h0;
   endfunction
   initial begin
      logic [31:0] q;
      logic e;
      logic [31:0] w;
      logic seen;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd("caps", 12'h004, 32'h3);
      rd("misc_off", 12'h024, 32'h0);
      apb(12'h040, 1'b0, 32'h0, q, e);
      chk("slverr", e, 1'b1);
      $display("reset test done");
      for (int s = 0; s < 4; s++) begin
         sel = s;
         apb(12'h008, 1'b1, sel, q, e);
         rd("misc_size", 12'h028, (s == 0) ? 32'h0 : ((s == 1) ? 32'h10 : 32'h20));
         if (s == 1) rd("misc_off", 12'h024, 32'hF40);
         for (int v = 0; v < 24; v++) begin
            exc(v[7:0], v == 3, 64'h0, 32'h0, 1'b1, 1'b0);
            w = exp_word(v[7:0], v == 3);
            chk("reason", frame_reason, w);
            chk("rec", rec_write, w[31] && (v == 13 || v == 14 || v == 21));
         end
      end
      $display("vector sweep done");
      exc(8'h0E, 1'b0, 64'h0000123456789ABC, 32'hFFFFFFFA, 1'b1, 1'b0);
      chk("pf_addr", rec_addr, 64'h0000123456789ABC);
      chk("pf_code", rec_err_code, (32'hFFFFFFFA & 32'h0000803B) | 32'h4);
      chk("reason_off", frame_reason_off, 32'hFF0);
      chk("rec_off", rec_base_off, 32'hF40);
      exc(8'h0D, 1'b0, 64'h5555, 32'h00000123, 1'b1, 1'b0);
      chk("gp_addr", rec_addr, 64'h0);
      chk("gp_code", rec_err_code, 32'h123);
      exc(8'h0E, 1'b0, 64'h7000, 32'h1, 1'b0, 1'b0);
      chk("pf_sup", rec_write, 1'b0);
      $display("record test done");
      exc(8'h01, 1'b0, 64'h0, 32'h0, 1'b1, 1'b1);
      chk("prio_word", frame_reason, 32'h0);
      @(posedge pclk);
      priority_event <= 1'b0;
      seen = 1'b0;
      repeat (4) begin
         @(negedge pclk);
         if (debug_redeliver === 1'b1) seen = 1'b1;
      end
      chk("redeliver", seen, 1'b1);
      $display("priority test done");
      end_sim();
   end
endmodule
bind eer_exit_record eer_props eer_props_inst (.pclk, .presetn, .exc_valid, .exc_info,
   .pf_user_ref, .priority_event, .frame_write, .frame_reason_off, .frame_reason, .rec_write,
   .rec_base_off, .rec_addr, .rec_err_code, .rec_rsvd);
